/* File: design/ats_pkg.sv */
// Package for the antenna tune sequencer: widths, timing, states, carriers.
// Assumes a single 100 MHz clock domain.
package ats_pkg;
  localparam int          CLK_MHZ       = 100;
  localparam int          RETUNE_MS     = 100;
  localparam int          RETUNE_CYC    = RETUNE_MS * 1000 * CLK_MHZ;
  localparam int          FLASH_MS      = 250;
  localparam int          FLASH_CYC     = FLASH_MS * 1000 * CLK_MHZ;
  localparam int          STEP_CYC      = 16;
  localparam int          IN_CAP_BITS   = 11;
  localparam int          SER_IND_BITS  = 11;
  localparam int          OUT_CAP_BITS  = 4;
  localparam int          CHAN_SLOTS    = 20;
  localparam int          RECENT_SLOTS  = 10;
  localparam logic [31:0] CNT_RESET     = 32'h0000_0000;
  localparam logic [4:0]  IDX_RESET     = 5'h00;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_TUNE    = 3'b001,
    ST_READY   = 3'b011,
    ST_FAULT   = 3'b101
  } ats_state_e;

  typedef struct packed {
    logic [IN_CAP_BITS-1:0]  inCap;
    logic [SER_IND_BITS-1:0] serInd;
    logic                    compCap;
    logic [OUT_CAP_BITS-1:0] outCap;
  } ats_net_s;

  typedef struct packed {
    logic tuneLamp;
    logic readyLamp;
    logic faultLamp;
  } ats_lamps_s;
endpackage

/* File: design/ats_antenna_tune_sequencer.sv */
// Tune sequencer: lamps, bypass, keying inhibit, element banks, tuning memory.
// Assumes an external search engine returning a setting and good/bad result.
// Function
// - Tune lamp lit during tuning cycle
// - Ready lamp after good match
// - Auto tune on high SWR after powerup/success
// - Original firmware retunes after 100 ms mismatch
// - Fault needs new tune request
// - Inhibit keying on fault except powerup
// - Powerup fault lamp steady or flashing
// - Bypass whenever fault lamp lit
// - Twenty channel or ten recent memories
// - Revised firmware: high SWR latches fault
// - Revised: request clears, mismatch gone relights
// - Keying line qualifies retune when fitted
// - Input capacitor bank eleven bits
// - Series inductors eleven bits plus compensation
// - Compensation capacitor only at high frequency
// - Output capacitor bank four bits
`timescale 1ns/1ps
module ats_antenna_tune_sequencer #(
  parameter int RETUNE_CYCLES = ats_pkg::RETUNE_CYC,
  parameter int FLASH_CYCLES  = ats_pkg::FLASH_CYC
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Requests and mode
  input  wire logic             tuneRequest,
  input  wire logic             panel_tune_button,
  input  wire logic             coupler_tune_position,
  input  wire logic             revisedFirmware,
  // Channel information
  input  wire logic             channelValid,
  input  wire logic [4:0]       channelNumber,
  // Sensing
  input  wire logic             swrHigh,
  input  wire logic             keyLine,
  input  wire logic             keying_ground_jumper,
  input  wire logic             highBand,
  input  wire logic             memoryRetained,
  // Search engine
  input  wire logic             searchDone,
  input  wire logic             searchGood,
  input  wire ats_pkg::ats_net_s searchSetting,
  output logic                  searchStart,
  // Outputs
  output ats_pkg::ats_net_s     network,
  output logic                  bypass,
  output logic                  keyInhibit,
  output ats_pkg::ats_lamps_s   lamps
);
  ats_pkg::ats_state_e stateQ;
  ats_pkg::ats_state_e stateD;
  logic [2:0]  swrSyncQ;
  logic [2:0]  keySyncQ;
  logic [2:0]  btnSyncQ;
  logic [2:0]  posSyncQ;
  logic        swrQ;
  logic        keyQ;
  logic        btnQ;
  logic        btnPrevQ;
  logic        reqPrevQ;
  logic        lostQ;
  logic        caughtQ;
  logic [31:0] mismatchCntQ;
  logic [31:0] flashCntQ;
  logic        flashQ;
  logic [4:0]  recentIdxQ;
  ats_pkg::ats_net_s memQ [ats_pkg::CHAN_SLOTS + ats_pkg::RECENT_SLOTS];
  logic        newRequest;
  logic        genuine;
  logic        retuneDue;
  logic [4:0]  slot;

  // Agreeing second and third stages
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      swrSyncQ <= 3'h0;
      keySyncQ <= 3'h0;
      btnSyncQ <= 3'h0;
      posSyncQ <= 3'h0;
      swrQ     <= 1'b0;
      keyQ     <= 1'b0;
      btnQ     <= 1'b0;
      btnPrevQ <= 1'b0;
      reqPrevQ <= 1'b0;
    end else begin
      swrSyncQ <= {swrSyncQ[1:0], swrHigh};
      keySyncQ <= {keySyncQ[1:0], keyLine};
      btnSyncQ <= {btnSyncQ[1:0], panel_tune_button};
      posSyncQ <= {posSyncQ[1:0], coupler_tune_position};
      swrQ     <= agreed(swrSyncQ, swrQ);
      keyQ     <= agreed(keySyncQ, keyQ);
      btnQ     <= agreed(btnSyncQ, btnQ) & posSyncQ[2] & posSyncQ[1];
      btnPrevQ <= btnQ;
      reqPrevQ <= tuneRequest;
    end
  end

  assign newRequest = (tuneRequest & ~reqPrevQ) | (btnQ & ~btnPrevQ);
  assign genuine    = swrQ & (keying_ground_jumper | keyQ);
  assign retuneDue  = (mismatchCntQ >= 32'(RETUNE_CYCLES));
  assign slot = channelValid ? ((channelNumber < 5'(ats_pkg::CHAN_SLOTS)) ? channelNumber
                                 : 5'h00)
                             : 5'(5'(ats_pkg::CHAN_SLOTS) + recentIdxQ);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mismatchCntQ <= ats_pkg::CNT_RESET;
    end else if (genuine && stateQ == ats_pkg::ST_READY) begin
      if (!retuneDue) mismatchCntQ <= mismatchCntQ + 32'h1;
    end else begin
      mismatchCntQ <= ats_pkg::CNT_RESET;
    end
  end

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ats_pkg::ST_POWERUP: begin
        if (newRequest || genuine) stateD = ats_pkg::ST_TUNE;
      end
      ats_pkg::ST_READY: begin
        if (newRequest) stateD = ats_pkg::ST_TUNE;
        else if (revisedFirmware && genuine) stateD = ats_pkg::ST_FAULT;
        else if (!revisedFirmware && retuneDue) stateD = ats_pkg::ST_TUNE;
      end
      ats_pkg::ST_TUNE: begin
        if (searchDone) stateD = searchGood ? ats_pkg::ST_READY : ats_pkg::ST_FAULT;
      end
      ats_pkg::ST_FAULT: begin
        if (newRequest) stateD = ats_pkg::ST_TUNE;
        else if (revisedFirmware && caughtQ && keyQ && !swrQ) stateD = ats_pkg::ST_READY;
      end
      default: stateD = ats_pkg::ST_POWERUP;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) stateQ <= ats_pkg::ST_POWERUP;
    else       stateQ <= stateD;
  end

  // Latched mismatch origin of fault
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) caughtQ <= 1'b0;
    else if (stateQ == ats_pkg::ST_READY && stateD == ats_pkg::ST_FAULT) caughtQ <= 1'b1;
    else if (stateD != ats_pkg::ST_FAULT) caughtQ <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) lostQ <= 1'b0;
    else if (stateQ == ats_pkg::ST_POWERUP) lostQ <= ~memoryRetained;
    else lostQ <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flashCntQ <= ats_pkg::CNT_RESET;
      flashQ    <= 1'b0;
    end else if (flashCntQ >= 32'(FLASH_CYCLES - 1)) begin
      flashCntQ <= ats_pkg::CNT_RESET;
      flashQ    <= ~flashQ;
    end else begin
      flashCntQ <= flashCntQ + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      recentIdxQ <= ats_pkg::IDX_RESET;
    end else if (stateQ == ats_pkg::ST_TUNE && searchDone && searchGood) begin
      if (!channelValid)
        recentIdxQ <= (recentIdxQ == 5'(ats_pkg::RECENT_SLOTS - 1)) ? 5'h00
                                                                   : recentIdxQ + 5'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (stateQ == ats_pkg::ST_TUNE && searchDone && searchGood) begin
      memQ[slot] <= searchSetting;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      network     <= '0;
      bypass      <= 1'b1;
      keyInhibit  <= 1'b0;
      lamps       <= '0;
      searchStart <= 1'b0;
    end else begin
      searchStart <= (stateD == ats_pkg::ST_TUNE) && (stateQ != ats_pkg::ST_TUNE);
      if (stateQ == ats_pkg::ST_TUNE && searchDone && searchGood) begin
        network <= searchSetting;
        network.compCap <= searchSetting.compCap & highBand;
      end
      bypass <= (stateD == ats_pkg::ST_FAULT) || (stateD == ats_pkg::ST_POWERUP);
      keyInhibit <= (stateD == ats_pkg::ST_FAULT);
      lamps.tuneLamp  <= (stateD == ats_pkg::ST_TUNE);
      lamps.readyLamp <= (stateD == ats_pkg::ST_READY);
      lamps.faultLamp <= (stateD == ats_pkg::ST_FAULT) ||
                         (stateD == ats_pkg::ST_POWERUP && (!lostQ || flashQ));
    end
  end

  tune_lamp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_TUNE |-> lamps.tuneLamp)
    else $error("tune lamp dark while tuning");
  ready_after_good_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_TUNE && searchDone && searchGood |=> lamps.readyLamp)
    else $error("ready lamp missing after good tune");
  auto_tune_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_POWERUP && genuine |=> searchStart && lamps.tuneLamp)
    else $error("no auto tune on high swr");
  fault_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_FAULT && !newRequest && !revisedFirmware
      |=> stateQ == ats_pkg::ST_FAULT)
    else $error("fault left without request");
  key_inhibit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_FAULT && $past(stateQ) == ats_pkg::ST_FAULT |-> keyInhibit)
    else $error("keying allowed in fault");
  bypass_fault_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    lamps.faultLamp |-> bypass)
    else $error("fault lamp without bypass");
  revised_fault_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_READY && revisedFirmware && genuine && !newRequest
      |=> stateQ == ats_pkg::ST_FAULT && lamps.faultLamp)
    else $error("revised mismatch did not fault");
  one_lamp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ != ats_pkg::ST_POWERUP && $past(stateQ) != ats_pkg::ST_POWERUP
      |-> $onehot({lamps.tuneLamp, lamps.readyLamp, lamps.faultLamp}))
    else $error("lamps not one-hot");
  comp_cap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(network.compCap) |-> $past(highBand))
    else $error("compensation without high band");

  tune_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    searchStart |-> lamps.tuneLamp)
    else $error("search started without tune lamp");
  start_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    searchStart |=> !searchStart)
    else $error("search start longer than one cycle");
  ready_lamp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_READY |-> lamps.readyLamp)
    else $error("ready lamp dark while ready");
  retune_orig_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_READY && !revisedFirmware && retuneDue |=> stateQ == ats_pkg::ST_TUNE)
    else $error("no retune after persistent mismatch");
  powerup_key_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_POWERUP |-> !keyInhibit)
    else $error("keying inhibited at powerup");
  fault_key_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    lamps.faultLamp && stateQ != ats_pkg::ST_POWERUP |-> keyInhibit)
    else $error("fault lamp without keying inhibit");
  steady_lamp_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rstn) && stateQ == ats_pkg::ST_POWERUP && $past(stateQ) == ats_pkg::ST_POWERUP
      && !$past(lostQ) |-> lamps.faultLamp)
    else $error("powerup lamp not steady");
  flash_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rstn) && stateQ == ats_pkg::ST_POWERUP && $past(stateQ) == ats_pkg::ST_POWERUP
      && $past(lostQ) && !$past(flashQ) |-> !lamps.faultLamp)
    else $error("lost memory lamp not flashing");
  powerup_bypass_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_POWERUP |-> bypass)
    else $error("no bypass at powerup");
  mem_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_TUNE && searchDone && searchGood
      |=> memQ[$past(slot)] == $past(searchSetting))
    else $error("tuning memory not written");
  recent_ring_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    recentIdxQ < 5'(ats_pkg::RECENT_SLOTS))
    else $error("recent index out of range");
  no_retune_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_READY && revisedFirmware && !genuine && !newRequest
      |=> stateQ == ats_pkg::ST_READY)
    else $error("revised firmware left ready");
  relight_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_FAULT && revisedFirmware && caughtQ && keyQ && !swrQ
      |=> lamps.readyLamp)
    else $error("ready lamp not relit");
  genuine_key_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_READY && !keying_ground_jumper && !keyQ && !newRequest && !retuneDue
      |=> stateQ == ats_pkg::ST_READY)
    else $error("retune or fault without key-down");
  bank_word_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_TUNE && searchDone && searchGood
      |=> network.inCap == $past(searchSetting.inCap)
        && network.serInd == $past(searchSetting.serInd)
        && network.outCap == $past(searchSetting.outCap))
    else $error("bank words not loaded");
  comp_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(network) && !$past(highBand) |-> !network.compCap)
    else $error("compensation switched at low band");

  tune_ok_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_TUNE ##1 stateQ == ats_pkg::ST_READY);
  tune_bad_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_TUNE ##1 stateQ == ats_pkg::ST_FAULT);
  retune_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_READY && retuneDue);
  relight_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == ats_pkg::ST_FAULT ##1 stateQ == ats_pkg::ST_READY);
endmodule

/* File: dv/ats_host_model.sv */
// Host side model: transceiver tune requests and the tuning search engine.
// Assumes the bench steers mode, answer delay, result and setting.
`timescale 1ns/1ps
module ats_host_model (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // Bench controls
  input  wire logic              autoMode,
  input  wire logic              startPress,
  input  wire logic              newChan,
  input  wire logic              goodIn,
  input  wire logic [3:0]        dly,
  input  wire ats_pkg::ats_net_s setIn,
  // Sequencer side
  input  wire logic              searchStart,
  output logic                   tuneRequest,
  output logic                   searchDone,
  output logic                   searchGood,
  output ats_pkg::ats_net_s      searchSetting
);
  logic [3:0] cntQ;
  logic       doneQ;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tuneRequest <= 1'b0;
    else tuneRequest <= autoMode ? newChan : startPress;
  end
  // Search answers dly+1 cycles after searchStart
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cntQ  <= 4'h0;
      doneQ <= 1'b0;
    end else begin
      doneQ <= (cntQ == 4'h1);
      if (searchStart) cntQ <= dly;
      else if (cntQ != 4'h0) cntQ <= cntQ - 4'h1;
    end
  end
  // Result lines carry junk outside the done pulse
  assign searchDone    = doneQ;
  assign searchGood    = doneQ ? goodIn : ~goodIn;
  assign searchSetting = doneQ ? setIn : ~setIn;
endmodule

/* File: dv/tb.sv */
// Testbench for the tune sequencer: lamps, bypass, inhibit, banks, retune.
// Assumes the host model answers every search start.
`timescale 1ns/1ps
module tb;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t value mismatch", $time); end end
  logic              sys_clk, rstn, panelBtn, tunePos, revisedFw, chanValid, swrHigh;
  logic              keyLine, jumper, highBand, memRet, autoMode, startPress, newChan, goodIn;
  logic [4:0]        chanNum;
  logic [3:0]        dly;
  ats_pkg::ats_net_s setIn;
  wire               tuneRequest, searchDone, searchGood, searchStart, bypass, keyInhibit;
  ats_pkg::ats_net_s searchSetting, network;
  ats_pkg::ats_lamps_s lamps;
  int                mismatches, checks, lows;

  ats_antenna_tune_sequencer #(.RETUNE_CYCLES(50), .FLASH_CYCLES(4)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .tuneRequest(tuneRequest), .panel_tune_button(panelBtn),
    .coupler_tune_position(tunePos), .revisedFirmware(revisedFw), .channelValid(chanValid),
    .channelNumber(chanNum), .swrHigh(swrHigh), .keyLine(keyLine),
    .keying_ground_jumper(jumper), .highBand(highBand), .memoryRetained(memRet),
    .searchDone(searchDone), .searchGood(searchGood), .searchSetting(searchSetting),
    .searchStart(searchStart), .network(network), .bypass(bypass),
    .keyInhibit(keyInhibit), .lamps(lamps));
  ats_host_model i_host (
    .sys_clk(sys_clk), .rstn(rstn), .autoMode(autoMode), .startPress(startPress),
    .newChan(newChan), .goodIn(goodIn), .dly(dly), .setIn(setIn),
    .searchStart(searchStart), .tuneRequest(tuneRequest), .searchDone(searchDone),
    .searchGood(searchGood), .searchSetting(searchSetting));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_lamps(input logic [2:0] e, input int n);
    int i;
    i = 0;
    while (lamps !== e && i < n) begin
      cyc(1);
      i++;
    end
    checks++;
    if (i >= n) begin
      mismatches++;
      $display("[ERR] %0t lamp wait timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(1);
  endtask
  task automatic pulse_chan();
    newChan <= 1'b1;
    cyc(1);
    newChan <= 1'b0;
  endtask

  initial begin
    {rstn, panelBtn, tunePos, revisedFw, chanValid, swrHigh, highBand, memRet} = 8'h00;
    {autoMode, startPress, newChan} = 3'h0;
    {jumper, keyLine, goodIn} = 3'h7;
    chanNum = 5'h13;
    dly = 4'h3;
    setIn = '{11'h5a5, 11'h3c3, 1'b1, 4'ha};
    mismatches = 0;
    checks = 0;
    for (int m = 0; m < 2; m++) begin
      memRet <= m[0];
      do_reset();
      lows = 0;
      repeat (12) begin
        cyc(1);
        lows += (lamps.faultLamp === 1'b0) ? 1 : 0;
      end
      `CHK(lows == 0, m == 1)
      `CHK({bypass, keyInhibit}, 2'b10)
    end
    swrHigh <= 1'b1;
    wait_lamps(3'b100, 10);
    swrHigh <= 1'b0;
    wait_lamps(3'b010, 20);
    `CHK(network, {setIn.inCap, setIn.serInd, 1'b0, setIn.outCap})
    `CHK(bypass, 1'b0)
    jumper <= 1'b0;
    keyLine <= 1'b0;
    swrHigh <= 1'b1;
    cyc(80);
    `CHK(lamps, 3'b010)
    keyLine <= 1'b1;
    goodIn <= 1'b0;
    cyc(40);
    `CHK(lamps, 3'b010)
    wait_lamps(3'b100, 30);
    wait_lamps(3'b001, 20);
    `CHK({bypass, keyInhibit}, 2'b11)
    swrHigh <= 1'b0;
    cyc(80);
    `CHK(lamps, 3'b001)
    goodIn <= 1'b1;
    highBand <= 1'b1;
    panelBtn <= 1'b1;
    cyc(8);
    `CHK(lamps, 3'b001)
    panelBtn <= 1'b0;
    tunePos <= 1'b1;
    cyc(6);
    panelBtn <= 1'b1;
    wait_lamps(3'b100, 10);
    {panelBtn, tunePos} <= 2'b00;
    wait_lamps(3'b010, 20);
    `CHK(network.compCap, 1'b1)
    revisedFw <= 1'b1;
    swrHigh <= 1'b1;
    wait_lamps(3'b001, 10);
    `CHK(keyInhibit, 1'b1)
    swrHigh <= 1'b0;
    wait_lamps(3'b010, 10);
    swrHigh <= 1'b1;
    wait_lamps(3'b001, 10);
    autoMode <= 1'b1;
    chanValid <= 1'b1;
    pulse_chan();
    wait_lamps(3'b100, 6);
    swrHigh <= 1'b0;
    wait_lamps(3'b010, 20);
    autoMode <= 1'b0;
    pulse_chan();
    cyc(6);
    `CHK(lamps, 3'b010)
    startPress <= 1'b1;
    cyc(1);
    startPress <= 1'b0;
    wait_lamps(3'b100, 6);
    wait_lamps(3'b010, 20);
    tally_and_finish();
  end
endmodule
